//--- rtl/sbl_map.svh
// Purpose: constants of the 16-bit load sequencer
// Assumes: one clock edge per T state
// Notes: opcode values, pair codes, T-state counts
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH

// ----------------------------------------
// prefix and opcode bytes
// ----------------------------------------
`define SBL_PFX_IDX_X 8'hdd
`define SBL_PFX_IDX_Y 8'hfd
`define SBL_PFX_EXT 8'hed
`define SBL_OP_IMM_IDX 8'h21
`define SBL_OP_LOAD_PTR 8'h2a
`define SBL_OP_STORE_PTR 8'h22
`define SBL_EXT_LOAD_LO 4'hb
`define SBL_EXT_STORE_LO 4'h3
`define SBL_IMM_LO 4'h1

// ----------------------------------------
// register file indices
// ----------------------------------------
`define SBL_IDX_FIRST 3'h0
`define SBL_IDX_SECOND 3'h1
`define SBL_IDX_PTR 3'h2
`define SBL_IDX_STACK 3'h3
`define SBL_IDX_X 3'h4
`define SBL_IDX_Y 3'h5
`define SBL_NUM_REGS 6

// ----------------------------------------
// T states per machine cycle and per instruction
// ----------------------------------------
`define SBL_T_FETCH 3'h4
`define SBL_T_MEM 3'h3
`define SBL_LEN_IMM 8'h0a
`define SBL_LEN_IDX_IMM 8'h0e
`define SBL_LEN_PTR_MEM 8'h10
`define SBL_LEN_PFX_MEM 8'h14

// ----------------------------------------
// reset values
// ----------------------------------------
`define SBL_PC_RST 16'h0000
`define SBL_REG_RST 16'h0000

`endif

//--- rtl/sbl_pkg.sv
// Purpose: types of the 16-bit load sequencer
// Assumes: constants come from sbl_map.svh
// Notes: none
package sbl_pkg;

  typedef enum logic [2:0] {
    S_FETCH, S_OPND_LO, S_OPND_HI, S_DATA_LO, S_DATA_HI
  } sbl_state_t;

  typedef enum logic [1:0] {K_IMM, K_LOAD, K_STORE} sbl_kind_t;

  typedef enum logic [1:0] {P_NONE, P_IDX_X, P_IDX_Y, P_EXT} sbl_pfx_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic m1;
  } sbl_bus_t;

endpackage

//--- rtl/sbl_regs.sv
// Purpose: pair and index register storage
// Assumes: one write port, two registered read ports
// Notes: read data appear one edge after the select
`timescale 1ns/1ns
`include "sbl_map.svh"
module sbl_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [2:0] wsel,
  input wire logic [15:0] wdata,
  input wire logic [2:0] rsel,
  input wire logic [2:0] dsel,
  output logic [15:0] rdata_r,
  output logic [15:0] ddata_r
);
  logic [15:0] mem_r [`SBL_NUM_REGS];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `SBL_NUM_REGS; i++) begin
        mem_r[i] <= `SBL_REG_RST;
      end
    end else if (we && wsel < 3'(`SBL_NUM_REGS)) begin
      mem_r[wsel] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= `SBL_REG_RST;
      ddata_r <= `SBL_REG_RST;
    end else begin
      rdata_r <= (rsel < 3'(`SBL_NUM_REGS)) ? mem_r[rsel] : `SBL_REG_RST;
      ddata_r <= (dsel < 3'(`SBL_NUM_REGS)) ? mem_r[dsel] : `SBL_REG_RST;
    end
  end
endmodule

//--- rtl/sbl_exec.sv
// Purpose: decode and bus sequencing of the 16-bit load group
// Assumes: one clock edge per T state; memory answers on the same clock
// Notes: read data are sampled in the last T state of each cycle
`timescale 1ns/1ns
`include "sbl_map.svh"
module sbl_exec (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] mem_rdata,
  input wire logic [2:0] dbg_sel,
  output sbl_pkg::sbl_bus_t mem_bus,
  output logic [15:0] dbg_data,
  output logic done,
  output logic bad_op,
  output logic flag_we
);
  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = v + 16'h0001;
  endfunction

  sbl_pkg::sbl_state_t st_r, st_nxt;
  sbl_pkg::sbl_kind_t kind_r, dec_kind;
  sbl_pkg::sbl_pfx_t pre_r, dec_pfx;
  sbl_pkg::sbl_bus_t bus_r, bus_nxt;
  logic [1:0] tcnt_r;
  logic [2:0] tgt_r, dec_tgt;
  logic [15:0] pc_r, waddr_r, rf_rdata, rf_wdata;
  logic [7:0] lo_r, dlo_r, op_r;
  logic last, fin, dec_ok, dec_is_pfx, rf_we, done_r, bad_r, flag_we_r;
  logic [7:0] cyc_r;

  assign mem_bus = bus_r;
  assign done = done_r;
  assign bad_op = bad_r;
  assign flag_we = flag_we_r;

  // ----------------------------------------
  // machine cycle timing
  // ----------------------------------------
  // fetch vs memory length
  always_comb begin
    if (st_r == sbl_pkg::S_FETCH) begin
      last = ({1'b0, tcnt_r} == `SBL_T_FETCH - 3'h1);
    end else begin
      last = ({1'b0, tcnt_r} == `SBL_T_MEM - 3'h1);
    end
  end

  assign fin = last && ((st_r == sbl_pkg::S_OPND_HI &&
    kind_r == sbl_pkg::K_IMM) || st_r == sbl_pkg::S_DATA_HI);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tcnt_r <= 2'h0;
    end else begin
      tcnt_r <= last ? 2'h0 : tcnt_r + 2'h1;
    end
  end

  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  always_comb begin
    dec_ok = 1'b0;
    dec_is_pfx = 1'b0;
    dec_kind = sbl_pkg::K_IMM;
    dec_tgt = `SBL_IDX_PTR;
    dec_pfx = sbl_pkg::P_NONE;
    if (mem_rdata == `SBL_PFX_IDX_X) begin
      dec_is_pfx = 1'b1;
      dec_pfx = sbl_pkg::P_IDX_X;
    end else if (mem_rdata == `SBL_PFX_IDX_Y) begin
      dec_is_pfx = 1'b1;
      dec_pfx = sbl_pkg::P_IDX_Y;
    end else if (mem_rdata == `SBL_PFX_EXT && pre_r == sbl_pkg::P_NONE) begin
      dec_is_pfx = 1'b1;
      dec_pfx = sbl_pkg::P_EXT;
    end else begin
      case (pre_r)
        sbl_pkg::P_NONE: begin
          if (mem_rdata[7:6] == 2'h0 && mem_rdata[3:0] == `SBL_IMM_LO) begin
            dec_ok = 1'b1;
            dec_tgt = {1'b0, mem_rdata[5:4]};
          end else if (mem_rdata == `SBL_OP_LOAD_PTR) begin
            dec_ok = 1'b1;
            dec_kind = sbl_pkg::K_LOAD;
          end else if (mem_rdata == `SBL_OP_STORE_PTR) begin
            dec_ok = 1'b1;
            dec_kind = sbl_pkg::K_STORE;
          end
        end
        sbl_pkg::P_EXT: begin
          dec_tgt = {1'b0, mem_rdata[5:4]};
          if (mem_rdata[7:6] == 2'h1) begin
            if (mem_rdata[3:0] == `SBL_EXT_LOAD_LO) begin
              dec_ok = 1'b1;
              dec_kind = sbl_pkg::K_LOAD;
            end else if (mem_rdata[3:0] == `SBL_EXT_STORE_LO) begin
              dec_ok = 1'b1;
              dec_kind = sbl_pkg::K_STORE;
            end
          end
        end
        default: begin
          dec_tgt = (pre_r == sbl_pkg::P_IDX_X) ? `SBL_IDX_X : `SBL_IDX_Y;
          if (mem_rdata == `SBL_OP_IMM_IDX) begin
            dec_ok = 1'b1;
          end else if (mem_rdata == `SBL_OP_LOAD_PTR) begin
            dec_ok = 1'b1;
            dec_kind = sbl_pkg::K_LOAD;
          end else if (mem_rdata == `SBL_OP_STORE_PTR) begin
            dec_ok = 1'b1;
            dec_kind = sbl_pkg::K_STORE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // sequence state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (last) begin
      case (st_r)
        sbl_pkg::S_FETCH:
          st_nxt = (dec_ok && !dec_is_pfx) ? sbl_pkg::S_OPND_LO
                                           : sbl_pkg::S_FETCH;
        sbl_pkg::S_OPND_LO: st_nxt = sbl_pkg::S_OPND_HI;
        sbl_pkg::S_OPND_HI:
          st_nxt = (kind_r == sbl_pkg::K_IMM) ? sbl_pkg::S_FETCH
                                              : sbl_pkg::S_DATA_LO;
        sbl_pkg::S_DATA_LO: st_nxt = sbl_pkg::S_DATA_HI;
        default: st_nxt = sbl_pkg::S_FETCH;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= sbl_pkg::S_FETCH;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= sbl_pkg::P_NONE;
      kind_r <= sbl_pkg::K_IMM;
      tgt_r <= `SBL_IDX_PTR;
      op_r <= 8'h00;
    end else if (last && st_r == sbl_pkg::S_FETCH) begin
      // prefix stays until the instruction ends, for the checks below
      pre_r <= dec_is_pfx ? dec_pfx : (dec_ok ? pre_r : sbl_pkg::P_NONE);
      if (dec_ok) begin
        kind_r <= dec_kind;
        tgt_r <= dec_tgt;
        op_r <= mem_rdata;
      end
    end else if (fin) begin
      pre_r <= sbl_pkg::P_NONE;
    end
  end

  // ----------------------------------------
  // operands and data bytes
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lo_r <= 8'h00;
      dlo_r <= 8'h00;
      waddr_r <= 16'h0000;
    end else if (last) begin
      if (st_r == sbl_pkg::S_OPND_LO) begin
        lo_r <= mem_rdata;
      end
      if (st_r == sbl_pkg::S_OPND_HI) begin
        waddr_r <= {mem_rdata, lo_r};
      end
      if (st_r == sbl_pkg::S_DATA_LO) begin
        dlo_r <= mem_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= `SBL_PC_RST;
    end else if (last && (st_r == sbl_pkg::S_FETCH ||
                          st_r == sbl_pkg::S_OPND_LO ||
                          st_r == sbl_pkg::S_OPND_HI)) begin
      pc_r <= inc16(pc_r);
    end
  end

  // ----------------------------------------
  // register file write back
  // ----------------------------------------
  assign rf_we = fin && kind_r != sbl_pkg::K_STORE;
  assign rf_wdata = (st_r == sbl_pkg::S_OPND_HI) ? {mem_rdata, lo_r}
                                                 : {mem_rdata, dlo_r};

  sbl_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .we(rf_we),
    .wsel(tgt_r),
    .wdata(rf_wdata),
    .rsel(tgt_r),
    .dsel(dbg_sel),
    .rdata_r(rf_rdata),
    .ddata_r(dbg_data)
  );

  // ----------------------------------------
  // memory bus
  // ----------------------------------------
  always_comb begin
    bus_nxt = bus_r;
    if (last) begin
      bus_nxt.m1 = (st_nxt == sbl_pkg::S_FETCH);
      bus_nxt.wr = (kind_r == sbl_pkg::K_STORE) &&
                   (st_nxt == sbl_pkg::S_DATA_LO ||
                    st_nxt == sbl_pkg::S_DATA_HI);
      bus_nxt.rd = !bus_nxt.wr;
      bus_nxt.wdata = 8'h00;
      case (st_nxt)
        sbl_pkg::S_DATA_LO: begin
          bus_nxt.addr = {mem_rdata, lo_r};
          if (bus_nxt.wr) begin
            bus_nxt.wdata = rf_rdata[7:0];
          end
        end
        sbl_pkg::S_DATA_HI: begin
          bus_nxt.addr = inc16(waddr_r);
          if (bus_nxt.wr) begin
            bus_nxt.wdata = rf_rdata[15:8];
          end
        end
        // pc is not stepped at the end of a data cycle
        default: bus_nxt.addr = (st_r == sbl_pkg::S_DATA_HI) ? pc_r
                                                             : inc16(pc_r);
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_r <= '{addr: `SBL_PC_RST, wdata: 8'h00, rd: 1'b1, wr: 1'b0,
                 m1: 1'b1};
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // ----------------------------------------
  // status pulses
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
      bad_r <= 1'b0;
      flag_we_r <= 1'b0;
      cyc_r <= 8'h00;
    end else begin
      done_r <= fin;
      bad_r <= last && st_r == sbl_pkg::S_FETCH && !dec_ok && !dec_is_pfx;
      flag_we_r <= 1'b0;
      if (fin || (last && st_r == sbl_pkg::S_FETCH && !dec_ok &&
          !dec_is_pfx)) begin
        cyc_r <= 8'h00;
      end else if (last && st_r == sbl_pkg::S_FETCH && dec_is_pfx &&
                   pre_r != sbl_pkg::P_NONE) begin
        // replaced prefix: count from the prefix that wins
        cyc_r <= 8'(`SBL_T_FETCH);
      end else begin
        cyc_r <= cyc_r + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_imm_pair_len: assert property (@(posedge clk) disable iff (!rstn)
    fin && kind_r == sbl_pkg::K_IMM && pre_r == sbl_pkg::P_NONE
    |-> cyc_r == `SBL_LEN_IMM - 8'h01)
    else $error("pair immediate load length wrong");
  a_imm_x_len: assert property (@(posedge clk) disable iff (!rstn)
    fin && kind_r == sbl_pkg::K_IMM && pre_r == sbl_pkg::P_IDX_X
    |-> cyc_r == `SBL_LEN_IDX_IMM - 8'h01 && tgt_r == `SBL_IDX_X)
    else $error("index x immediate load wrong");
  a_imm_y_len: assert property (@(posedge clk) disable iff (!rstn)
    fin && kind_r == sbl_pkg::K_IMM && pre_r == sbl_pkg::P_IDX_Y
    |-> cyc_r == `SBL_LEN_IDX_IMM - 8'h01 && tgt_r == `SBL_IDX_Y)
    else $error("index y immediate load wrong");
  a_ptr_mem_len: assert property (@(posedge clk) disable iff (!rstn)
    fin && kind_r != sbl_pkg::K_IMM && pre_r == sbl_pkg::P_NONE
    |-> cyc_r == `SBL_LEN_PTR_MEM - 8'h01 && tgt_r == `SBL_IDX_PTR)
    else $error("pointer pair memory access length wrong");
  a_pfx_mem_len: assert property (@(posedge clk) disable iff (!rstn)
    fin && kind_r != sbl_pkg::K_IMM && pre_r != sbl_pkg::P_NONE
    |-> cyc_r == `SBL_LEN_PFX_MEM - 8'h01)
    else $error("prefixed memory access length wrong");
  a_pair_select: assert property (@(posedge clk) disable iff (!rstn)
    fin && pre_r != sbl_pkg::P_IDX_X && pre_r != sbl_pkg::P_IDX_Y
    && op_r != `SBL_OP_LOAD_PTR && op_r != `SBL_OP_STORE_PTR
    |-> tgt_r == {1'b0, op_r[5:4]})
    else $error("pair select decode wrong");
  a_addr_order: assert property (@(posedge clk) disable iff (!rstn)
    st_r == sbl_pkg::S_DATA_LO && tcnt_r == 2'h0
    |-> bus_r.addr == waddr_r && bus_r.addr[7:0] == lo_r)
    else $error("address byte order wrong");
  a_addr_wrap: assert property (@(posedge clk) disable iff (!rstn)
    st_r == sbl_pkg::S_DATA_LO && last
    |=> bus_r.addr == $past(bus_r.addr) + 16'h0001)
    else $error("second address not nn+1");
  a_store_bytes: assert property (@(posedge clk) disable iff (!rstn)
    st_r == sbl_pkg::S_DATA_LO && kind_r == sbl_pkg::K_STORE && last
    |-> bus_r.wr && bus_r.wdata == rf_rdata[7:0]
    ##1 bus_r.wr && bus_r.wdata == rf_rdata[15:8])
    else $error("store byte order wrong");
  a_fetch_len: assert property (@(posedge clk) disable iff (!rstn)
    st_r == sbl_pkg::S_FETCH && tcnt_r == 2'h0
    |-> (bus_r.m1 && bus_r.rd)[*4] ##1 tcnt_r == 2'h0)
    else $error("fetch cycle not four T states");
  a_flags_kept: assert property (@(posedge clk) disable iff (!rstn)
    done_r |-> !flag_we_r && !$past(flag_we_r))
    else $error("flags written by a load");
endmodule

//--- sim/sbl_mem_model.sv
// Purpose: byte memory on the far side of the load sequencer
// Assumes: no wait states, read data valid through the whole cycle
// Notes: while not reading, the data lines show the inverse of the last byte
`timescale 1ns/1ns
module sbl_mem_model (
  input wire logic clk,
  input wire sbl_pkg::sbl_bus_t mem_bus,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  // released lines must not repeat the last byte
  always_comb begin
    if (mem_bus.rd) begin
      mem_rdata = mem[mem_bus.addr];
    end else begin
      mem_rdata = ~last_r;
    end
  end

  always @(posedge clk) begin
    if (mem_bus.rd) begin
      last_r <= mem[mem_bus.addr];
    end
    if (mem_bus.wr) begin
      mem[mem_bus.addr] <= mem_bus.wdata;
    end
  end
endmodule

//--- sim/sixteen_bit_load_exec_tb_top.sv
// Purpose: self-checking bench of the 16-bit load sequencer
// Assumes: program bytes are placed just ahead of the fetch address
// Notes: register contents are read back through the debug port
`timescale 1ns/1ns
`include "sbl_map.svh"
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module sixteen_bit_load_exec_tb_top;
  logic clk;
  logic rstn;
  logic [2:0] dbg_sel;
  logic [7:0] mem_rdata;
  sbl_pkg::sbl_bus_t mem_bus;
  logic [15:0] dbg_data;
  logic done;
  logic bad_op;
  logic flag_we;
  logic flag_seen = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [15:0] er [0:5];
  int errors = 0;
  int num_checks = 0;
  int tick = 0;
  int last_tick = 0;
  int bad_cnt = 0;

  sbl_exec i_dut (.clk(clk), .rstn(rstn), .mem_rdata(mem_rdata),
    .dbg_sel(dbg_sel), .mem_bus(mem_bus), .dbg_data(dbg_data),
    .done(done), .bad_op(bad_op), .flag_we(flag_we));
  sbl_mem_model i_mem (.clk(clk), .mem_bus(mem_bus),
    .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    tick <= tick + 1;
    if (rstn && flag_we !== 1'b0) flag_seen <= 1'b1;
    if (bad_op === 1'b1) bad_cnt <= bad_cnt + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic put(input logic [7:0] b);
    i_mem.mem[pc] = b;
    pc = pc + 16'h0001;
  endtask

  task automatic setw(input logic [15:0] a, input logic [15:0] w);
    i_mem.mem[a] = w[7:0];
    i_mem.mem[a + 16'h0001] = w[15:8];
  endtask

  // len 0 skips the T-state count
  task automatic wait_done(input int len);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    `CHK(n < 100, 1'b1)
    if (len != 0) `CHK(tick - last_tick, len)
    last_tick = tick;
  endtask

  task automatic op(input logic [7:0] pfx, input logic [7:0] opc,
                    input logic [15:0] nn, input int len);
    if (pfx !== 8'h00) put(pfx);
    put(opc);
    put(nn[7:0]);
    put(nn[15:8]);
    wait_done(len);
  endtask

  task automatic chk_reg(input logic [2:0] sel, input logic [15:0] w);
    dbg_sel = sel;
    @(negedge clk);
    @(negedge clk);
    `CHK(dbg_data, w)
  endtask

  task automatic chk_mem(input logic [15:0] nn, input logic [15:0] w);
    `CHK({i_mem.mem[nn + 16'h0001], i_mem.mem[nn]}, w)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_imm;
    for (int p = 0; p < 4; p++) begin
      er[p] = {8'h91 + 8'(p), 8'h2c + 8'(p)};
      op(8'h00, {2'b00, 2'(p), `SBL_IMM_LO}, er[p], (p == 0) ? 0 : 10);
      chk_reg(3'(p), er[p]);
    end
    $display("test imm done");
  endtask

  task automatic t_idx_imm;
    er[4] = 16'h6e19;
    er[5] = 16'hd387;
    op(`SBL_PFX_IDX_X, `SBL_OP_IMM_IDX, er[4], 14);
    chk_reg(`SBL_IDX_X, er[4]);
    op(`SBL_PFX_IDX_Y, `SBL_OP_IMM_IDX, er[5], 14);
    chk_reg(`SBL_IDX_Y, er[5]);
    $display("test index imm done");
  endtask

  task automatic t_load;
    logic [15:0] nn;
    er[2] = 16'hb7e4;
    setw(16'h3000, er[2]);
    op(8'h00, `SBL_OP_LOAD_PTR, 16'h3000, 16);
    chk_reg(`SBL_IDX_PTR, er[2]);
    for (int p = 0; p < 4; p++) begin
      nn = 16'h3010 + 16'(2 * p);
      er[p] = {8'h5a + 8'(p), 8'hc0 + 8'(p)};
      setw(nn, er[p]);
      op(`SBL_PFX_EXT, {2'b01, 2'(p), `SBL_EXT_LOAD_LO}, nn, 20);
      chk_reg(3'(p), er[p]);
    end
    er[4] = 16'h0fa3;
    setw(16'h3020, er[4]);
    op(`SBL_PFX_IDX_X, `SBL_OP_LOAD_PTR, 16'h3020, 20);
    chk_reg(`SBL_IDX_X, er[4]);
    er[5] = 16'h7c5e;
    setw(16'h3030, er[5]);
    op(`SBL_PFX_IDX_Y, `SBL_OP_LOAD_PTR, 16'h3030, 20);
    chk_reg(`SBL_IDX_Y, er[5]);
    // high byte comes from address 0000, the first program byte
    i_mem.mem[16'hffff] = 8'h4d;
    er[1] = {4'h0, `SBL_IMM_LO, 8'h4d};
    op(`SBL_PFX_EXT, {4'h5, `SBL_EXT_LOAD_LO}, 16'hffff, 20);
    chk_reg(`SBL_IDX_SECOND, er[1]);
    $display("test load done");
  endtask

  task automatic t_store;
    logic [15:0] nn;
    op(8'h00, `SBL_OP_STORE_PTR, 16'h4000, 16);
    chk_mem(16'h4000, er[2]);
    for (int p = 0; p < 4; p++) begin
      nn = 16'h4010 + 16'(2 * p);
      op(`SBL_PFX_EXT, {2'b01, 2'(p), `SBL_EXT_STORE_LO}, nn, 20);
      chk_mem(nn, er[p]);
    end
    op(`SBL_PFX_IDX_X, `SBL_OP_STORE_PTR, 16'h4020, 20);
    chk_mem(16'h4020, er[4]);
    op(`SBL_PFX_IDX_Y, `SBL_OP_STORE_PTR, 16'h4030, 20);
    chk_mem(16'h4030, er[5]);
    op(`SBL_PFX_EXT, {4'h4, `SBL_EXT_STORE_LO}, 16'hffff, 20);
    chk_mem(16'hffff, er[0]);
    $display("test store done");
  endtask

  // unknown byte skipped, then a later prefix replaces an earlier one
  task automatic t_bad;
    put(8'h00);
    put(`SBL_PFX_IDX_X);
    op(`SBL_PFX_IDX_Y, `SBL_OP_IMM_IDX, 16'h29d1, 0);
    chk_reg(`SBL_IDX_Y, 16'h29d1);
    chk_reg(`SBL_IDX_X, er[4]);
    `CHK(bad_cnt, 1)
    $display("test bad op done");
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    dbg_sel = 3'h0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_imm;
    t_idx_imm;
    t_load;
    t_store;
    t_bad;
    `CHK(flag_seen, 1'b0)
    complete_run;
  end

  initial begin
    #10000;
    errors++;
    complete_run;
  end
endmodule
